// ==== logic/sam_mapper.sv ====
`timescale 1ns/10ps
`default_nettype none

// Operation
// - 16 Mbit: bank select zero from A11, row lines from A22..A12.
// - 16 Mbit column: line ten zero, A24, A23, then A10..A3.
// - 64/128 Mbit two-bank: A11 on bank select, row from A24..A12.
// - 64/128 Mbit two-bank column: lines 12..10 zero, A26, A25, A10..A3.
// - 64/128 Mbit four-bank: A11, A12 on bank selects, row A24..A13.
// - four-bank column: selects kept, lines 11..10 zero, A26, A25, A10..A3.
// - 64/128 Mbit: third chip-select pin carries address line eleven.
// - fourth chip-select pin: line twelve two-bank, bank select one four-bank.
// - 16 Mbit parts: four external banks, each with its own select.
// - total addressable memory is at most 128 megabytes.
// - graphics at bottom of bank 0, host memory placed just above.
// - synchronous mode completes every accepted access four memory cycles sooner; refused ones take the same time.
// - asynchronous mode accepts memory clock ratio changes only while the sequencer is idle, between accesses.
// - synchronous strap forces memory clock equal to host clock.
module sam_mapper
(
	input  wire logic                      clk_i,
	input  wire logic                      nrst_i,
	input  wire logic                      req_valid_i,
	output logic                           req_ready_o,
	input  wire logic [sam_pkg::HA_W-1:0]  req_addr_i,
	input  wire logic                      req_gfx_i,
	output logic                           done_o,
	output logic                           err_o,
	input  wire logic [1:0]                density_i,
	input  wire logic                      four_bank_i,
	input  wire logic [3:0]                populated_i,
	input  wire logic [sam_pkg::HA_W-1:0]  gfx_size_i,
	input  wire logic                      sync_strap_i,
	input  wire logic [3:0]                mclk_div_i,
	output logic [3:0]                     mclk_div_o,
	output logic [10:0]                    mem_addr_lines_o,
	output logic                           bank_select_zero_o,
	output logic                           first_bank_select_n_o,
	output logic                           second_bank_select_n_o,
	output logic                           third_bank_select_n_o,
	output logic                           fourth_bank_select_n_o,
	output logic                           row_strobe_n_o,
	output logic                           col_strobe_n_o
);

	// ************************************************************
	// pin synchronisers for straps and configuration
	// ************************************************************
	logic [1:0]               dens_s1_reg;
	logic [1:0]               dens_reg;
	logic                     four_s1_reg;
	logic                     four_reg;
	logic [3:0]               pop_s1_reg;
	logic [3:0]               pop_reg;
	logic [sam_pkg::HA_W-1:0] gfx_s1_reg;
	logic [sam_pkg::HA_W-1:0] gfx_reg;
	logic                     sync_s1_reg;
	logic                     sync_reg;
	logic [3:0]               div_s1_reg;
	logic [3:0]               div_reg;

	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			dens_s1_reg <= 2'h0;
			dens_reg    <= 2'h0;
			four_s1_reg <= 1'b0;
			four_reg    <= 1'b0;
			pop_s1_reg  <= 4'h0;
			pop_reg     <= 4'h0;
			gfx_s1_reg  <= '0;
			gfx_reg     <= '0;
			sync_s1_reg <= 1'b0;
			sync_reg    <= 1'b0;
			div_s1_reg  <= 4'h0;
			div_reg     <= 4'h0;
		end
		else
		begin
			dens_s1_reg <= density_i;
			dens_reg    <= dens_s1_reg;
			four_s1_reg <= four_bank_i;
			four_reg    <= four_s1_reg;
			pop_s1_reg  <= populated_i;
			pop_reg     <= pop_s1_reg;
			gfx_s1_reg  <= gfx_size_i;
			gfx_reg     <= gfx_s1_reg;
			sync_s1_reg <= sync_strap_i;
			sync_reg    <= sync_s1_reg;
			div_s1_reg  <= mclk_div_i;
			div_reg     <= div_s1_reg;
		end
	end

	// ************************************************************
	// request decode
	// ************************************************************
	sam_pkg::sam_state_t        state_reg;
	sam_pkg::sam_state_t        state_next;
	logic [sam_pkg::HA_W-1:0]   addr_reg;
	logic [1:0]                 bank_reg;
	logic                       big_reg;
	logic                       quad_reg;
	logic [sam_pkg::CNT_W-1:0]  cnt_reg;
	logic [sam_pkg::CNT_W-1:0]  cnt_next;
	logic                       err_reg;
	logic [3:0]                 div_out_reg;

	wire logic                  is_16m;
	wire logic                  quad;
	wire logic [27:0]           eff_wide;
	wire logic [sam_pkg::HA_W-1:0] eff;
	wire logic [1:0]            bank_idx;
	wire logic [3:0]            pop_eff;
	wire logic [3:0]            pop_legal;
	wire logic                  over_max;
	wire logic                  bank_absent;
	wire logic                  take;
	wire logic [sam_pkg::CNT_W-1:0] wait_cyc;

	assign is_16m   = (dens_reg == sam_pkg::DENS_16M);
	assign quad     = four_reg & ~is_16m;
	// host space starts right above the graphics area
	assign eff_wide = req_gfx_i ? {1'b0, req_addr_i}
	                            : {1'b0, req_addr_i} + {1'b0, gfx_reg};
	assign eff      = eff_wide[sam_pkg::HA_W-1:0];
	// bank index from the bits above one bank's capacity
	assign bank_idx = is_16m ? eff[sam_pkg::BK16_LO +: 2] :
	                  (dens_reg == sam_pkg::DENS_64M) ? {1'b0, eff[sam_pkg::BK64_BIT]} :
	                  2'h0;
	assign pop_eff   = pop_reg | sam_pkg::BANK0_MASK;
	// wide parts give two selects over to address, so banks 2 and 3 vanish
	assign pop_legal = is_16m ? pop_eff : (pop_eff & sam_pkg::WIDE_POP_MASK);
	assign over_max    = (eff_wide >= sam_pkg::MEM_MAX_BYTES);
	assign bank_absent = ~pop_legal[bank_idx];
	assign req_ready_o = (state_reg == sam_pkg::SAM_IDLE);
	assign take        = req_valid_i & req_ready_o;
	// async crossing costs four extra memory cycles on the first beat
	assign wait_cyc    = sync_reg ? sam_pkg::CNT_W'(sam_pkg::RCD_CYC - 1)
	                              : sam_pkg::CNT_W'(sam_pkg::RCD_CYC + sam_pkg::ASYNC_EXTRA_CYC - 1);

	// ************************************************************
	// access sequencer
	// ************************************************************
	always_comb
	begin
		state_next = state_reg;
		cnt_next   = cnt_reg;
		case (state_reg)
			sam_pkg::SAM_IDLE:
			begin
				if (take)
				begin
					state_next = (over_max | bank_absent) ? sam_pkg::SAM_DONE : sam_pkg::SAM_ROW;
				end
			end
			sam_pkg::SAM_ROW:
			begin
				state_next = sam_pkg::SAM_WAIT;
				cnt_next   = wait_cyc;
			end
			sam_pkg::SAM_WAIT:
			begin
				if (cnt_reg == '0)
				begin
					state_next = sam_pkg::SAM_COL;
				end
				else
				begin
					cnt_next = cnt_reg - 1'b1;
				end
			end
			sam_pkg::SAM_COL:
			begin
				state_next = sam_pkg::SAM_DONE;
			end
			sam_pkg::SAM_DONE:
			begin
				state_next = sam_pkg::SAM_IDLE;
			end
			default:
			begin
				state_next = sam_pkg::SAM_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			state_reg <= sam_pkg::SAM_IDLE;
			cnt_reg   <= '0;
		end
		else
		begin
			state_reg <= state_next;
			cnt_reg   <= cnt_next;
		end
	end

	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			addr_reg <= '0;
			bank_reg <= 2'h0;
			big_reg  <= 1'b0;
			quad_reg <= 1'b0;
			err_reg  <= 1'b0;
		end
		else if (take)
		begin
			addr_reg <= eff;
			bank_reg <= bank_idx;
			big_reg  <= ~is_16m;
			quad_reg <= quad;
			err_reg  <= over_max | bank_absent;
		end
	end

	// ************************************************************
	// memory clock ratio
	// ************************************************************
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			div_out_reg <= sam_pkg::DIV_SYNC;
		end
		else if (sync_reg)
		begin
			div_out_reg <= sam_pkg::DIV_SYNC;
		end
		else if (state_reg == sam_pkg::SAM_IDLE)
		begin
			div_out_reg <= div_reg;
		end
	end

	assign mclk_div_o = div_out_reg;

	// ************************************************************
	// row and column fields
	// ************************************************************
	wire logic [sam_pkg::LN_W-1:0] row_v;
	wire logic [sam_pkg::LN_W-1:0] col_v;
	wire logic [sam_pkg::LN_W-1:0] lines;
	wire logic                     in_row;
	wire logic                     in_col;
	wire logic                     active;
	wire logic [3:0]               cs_n;

	assign row_v = ~big_reg ? {2'b00, addr_reg[sam_pkg::ROW16_HI:sam_pkg::ROW2_LO]} :
	               ~quad_reg ? addr_reg[sam_pkg::ROW64_HI:sam_pkg::ROW2_LO] :
	               {1'b0, addr_reg[sam_pkg::ROW64_HI:sam_pkg::ROW4_LO]};
	assign col_v = ~big_reg ? {3'b000, addr_reg[sam_pkg::C16_HI], addr_reg[sam_pkg::C16_LO],
	                           addr_reg[sam_pkg::COL_HI:sam_pkg::COL_LO]} :
	               {3'b000, addr_reg[sam_pkg::C64_HI], addr_reg[sam_pkg::C64_LO],
	                addr_reg[sam_pkg::COL_HI:sam_pkg::COL_LO]};
	assign in_row = (state_reg == sam_pkg::SAM_ROW) | (state_reg == sam_pkg::SAM_WAIT);
	assign in_col = (state_reg == sam_pkg::SAM_COL);
	assign active = in_row | in_col;
	assign lines  = in_col ? col_v : row_v;
	assign cs_n   = active ? ~(4'h1 << bank_reg) : 4'hF;

	// ************************************************************
	// pin drive
	// ************************************************************
	logic [10:0] ma_reg;
	logic        ba0_reg;
	logic [3:0]  pin_cs_n_reg;
	logic        ras_n_reg;
	logic        cas_n_reg;
	logic        done_reg;
	logic        errp_reg;

	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			ma_reg       <= 11'h000;
			ba0_reg      <= 1'b0;
			pin_cs_n_reg <= 4'hF;
			ras_n_reg    <= 1'b1;
			cas_n_reg    <= 1'b1;
			done_reg     <= 1'b0;
			errp_reg     <= 1'b0;
		end
		else
		begin
			ma_reg          <= lines[10:0];
			ba0_reg         <= addr_reg[sam_pkg::BA0_BIT];
			pin_cs_n_reg[0] <= cs_n[0];
			pin_cs_n_reg[1] <= cs_n[1];
			pin_cs_n_reg[2] <= big_reg ? lines[11] : cs_n[2];
			pin_cs_n_reg[3] <= ~big_reg ? cs_n[3] :
			                   quad_reg ? addr_reg[sam_pkg::BA1_BIT] : lines[12];
			ras_n_reg       <= ~(state_reg == sam_pkg::SAM_ROW);
			cas_n_reg       <= ~in_col;
			done_reg        <= (state_reg == sam_pkg::SAM_DONE);
			errp_reg        <= (state_reg == sam_pkg::SAM_DONE) & err_reg;
		end
	end

	// every bank is one 64-bit row of devices, so no lane steering here
	assign mem_addr_lines_o       = ma_reg;
	assign bank_select_zero_o     = ba0_reg;
	assign first_bank_select_n_o  = pin_cs_n_reg[0];
	assign second_bank_select_n_o = pin_cs_n_reg[1];
	assign third_bank_select_n_o  = pin_cs_n_reg[2];
	assign fourth_bank_select_n_o = pin_cs_n_reg[3];
	assign row_strobe_n_o         = ras_n_reg;
	assign col_strobe_n_o         = cas_n_reg;
	assign done_o                 = done_reg;
	assign err_o                  = errp_reg;

endmodule
`default_nettype wire

// ==== logic/sam_pkg.sv ====
`default_nettype none
package sam_pkg;

	// ************************************************************
	// address field positions
	// ************************************************************
	localparam int HA_W        = 27;
	localparam int LN_W        = 13;
	localparam int BA0_BIT     = 11;
	localparam int BA1_BIT     = 12;
	localparam int ROW2_LO     = 12;
	localparam int ROW4_LO     = 13;
	localparam int COL_LO      = 3;
	localparam int COL_HI      = 10;
	localparam int C16_HI      = 24;
	localparam int C16_LO      = 23;
	localparam int C64_HI      = 26;
	localparam int C64_LO      = 25;
	localparam int BK16_LO     = 24;
	localparam int BK64_BIT    = 26;
	localparam int ROW16_HI    = 22;
	localparam int ROW64_HI    = 24;

	// ************************************************************
	// capacity and density encodings
	// ************************************************************
	localparam logic [27:0] MEM_MAX_BYTES = 28'h8000000;
	localparam logic [1:0]  DENS_16M      = 2'h0;
	localparam logic [1:0]  DENS_64M      = 2'h1;
	localparam logic [1:0]  DENS_128M     = 2'h2;
	localparam logic [3:0]  BANK0_MASK    = 4'h1;
	localparam logic [3:0]  WIDE_POP_MASK = 4'h3;

	// ************************************************************
	// timing
	// ************************************************************
	localparam int CLK_PS           = 5000;
	localparam int RCD_NS           = 20;
	localparam int RCD_CYC          = (RCD_NS * 1000 + CLK_PS - 1) / CLK_PS;
	localparam int ASYNC_EXTRA_CYC  = 4;
	localparam int CNT_W            = 4;
	localparam logic [3:0] DIV_SYNC = 4'h1;

	typedef enum logic [2:0] {
		SAM_IDLE,
		SAM_ROW,
		SAM_WAIT,
		SAM_COL,
		SAM_DONE
	} sam_state_t;

endpackage
`default_nettype wire

// ==== sim/sam_mapper_properties.sv ====
`timescale 1ns/10ps
`default_nettype none
module sam_mapper_properties
(
	input wire logic        clk_i,
	input wire logic        nrst_i,
	input wire logic [1:0]  density_i,
	input wire logic        four_bank_i,
	input wire logic        sync_strap_i,
	input wire logic [3:0]  mclk_div_o,
	input wire logic [10:0] mem_addr_lines_o,
	input wire logic        bank_select_zero_o,
	input wire logic        first_bank_select_n_o,
	input wire logic        second_bank_select_n_o,
	input wire logic        third_bank_select_n_o,
	input wire logic        fourth_bank_select_n_o,
	input wire logic        row_strobe_n_o,
	input wire logic        col_strobe_n_o,
	input wire logic        done_o,
	input wire logic        err_o
);
	default clocking dc @(posedge clk_i);
	endclocking
	default disable iff (!nrst_i);
	wire logic narrow_w = density_i == sam_pkg::DENS_16M;
	property p_sync_lat;
		!row_strobe_n_o && sync_strap_i |=> col_strobe_n_o [*4] ##1 !col_strobe_n_o ##1 done_o;
	endproperty
	a_sync_lat: assert property (p_sync_lat) else $error("bad sync timing");
	property p_async_lat;
		!row_strobe_n_o && !sync_strap_i |=> col_strobe_n_o [*8] ##1 !col_strobe_n_o ##1 done_o;
	endproperty
	a_async_lat: assert property (p_async_lat) else $error("bad async timing");
	property p_col_narrow;
		!col_strobe_n_o && narrow_w |-> !mem_addr_lines_o[10];
	endproperty
	a_col_narrow: assert property (p_col_narrow) else $error("bad column line ten");
	property p_col_wide;
		!col_strobe_n_o && !narrow_w |-> !mem_addr_lines_o[10] && !third_bank_select_n_o
			&& (four_bank_i || !fourth_bank_select_n_o);
	endproperty
	a_col_wide: assert property (p_col_wide) else $error("bad wide column lines");
	property p_bank_hold;
		!col_strobe_n_o |-> bank_select_zero_o == $past(bank_select_zero_o, 5)
			&& (narrow_w || !four_bank_i || fourth_bank_select_n_o == $past(fourth_bank_select_n_o, 5));
	endproperty
	a_bank_hold: assert property (p_bank_hold) else $error("bank select moved");
	property p_one_sel;
		!row_strobe_n_o |-> narrow_w ? $countones({first_bank_select_n_o, second_bank_select_n_o,
			third_bank_select_n_o, fourth_bank_select_n_o}) == 3 : first_bank_select_n_o ^ second_bank_select_n_o;
	endproperty
	a_one_sel: assert property (p_one_sel) else $error("select count wrong");
	property p_err_quiet;
		err_o |-> done_o && row_strobe_n_o && col_strobe_n_o && $past(row_strobe_n_o) && $past(row_strobe_n_o, 2)
			&& $past(first_bank_select_n_o) && $past(second_bank_select_n_o);
	endproperty
	a_err_quiet: assert property (p_err_quiet) else $error("refusal not quiet");
	property p_mclk_sync;
		sync_strap_i && $past(sync_strap_i, 4) && $past(nrst_i, 4) |-> mclk_div_o == sam_pkg::DIV_SYNC;
	endproperty
	a_mclk_sync: assert property (p_mclk_sync) else $error("sync ratio wrong");
endmodule
bind sam_mapper sam_mapper_properties chk_u (.clk_i, .nrst_i, .density_i, .four_bank_i, .sync_strap_i,
	.mclk_div_o, .mem_addr_lines_o, .bank_select_zero_o, .first_bank_select_n_o, .second_bank_select_n_o,
	.third_bank_select_n_o, .fourth_bank_select_n_o, .row_strobe_n_o, .col_strobe_n_o, .done_o, .err_o);
`default_nettype wire

// ==== sim/sam_mapper_tb.sv ====
`timescale 1ns/10ps
`default_nettype none
module sam_mapper_tb;
	logic clk_i = 1'b0, nrst_i = 1'b0, req_valid_i = 1'b0, req_gfx_i = 1'b0;
	logic four_bank_i = 1'b0, sync_strap_i = 1'b0;
	logic [sam_pkg::HA_W-1:0] req_addr_i = 27'h0, gfx_size_i = 27'h0;
	logic [1:0] density_i = 2'h0;
	logic [3:0] populated_i = 4'h1, mclk_div_i = 4'h1, mclk_div_o;
	logic req_ready_o, done_o, err_o, bank_select_zero_o, first_bank_select_n_o, second_bank_select_n_o;
	logic third_bank_select_n_o, fourth_bank_select_n_o, row_strobe_n_o, col_strobe_n_o;
	logic [10:0] mem_addr_lines_o;
	logic [13:0] row_q, col_q;
	logic [1:0] cs_q;
	logic [7:0] acts_q;
	int failures = 0;
	int num_checks = 0;
	always #2.5 clk_i = ~clk_i;
	sam_mapper dut_u (.clk_i, .nrst_i, .req_valid_i, .req_ready_o, .req_addr_i, .req_gfx_i, .done_o, .err_o,
		.density_i, .four_bank_i, .populated_i, .gfx_size_i, .sync_strap_i, .mclk_div_i, .mclk_div_o,
		.mem_addr_lines_o, .bank_select_zero_o, .first_bank_select_n_o, .second_bank_select_n_o,
		.third_bank_select_n_o, .fourth_bank_select_n_o, .row_strobe_n_o, .col_strobe_n_o);
	sam_sdram_model mdl_u (.clk_i, .ras_n_i(row_strobe_n_o), .cas_n_i(col_strobe_n_o), .row_o(row_q),
		.pins_i({bank_select_zero_o, fourth_bank_select_n_o, third_bank_select_n_o, mem_addr_lines_o}),
		.cs_n_i({second_bank_select_n_o, first_bank_select_n_o}), .col_o(col_q), .cs_o(cs_q), .acts_o(acts_q));
	task automatic stop_test();
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic chk(input logic [31:0] s, input logic [31:0] x);
		num_checks++;
		if (s !== x)
		begin
			failures++;
			$display("unexpected at %0t: saw %h want %h", $time, s, x);
		end
	endtask
	// expected pins: bank select zero, fourth pin, third pin, eleven lines
	function automatic logic [13:0] f_pin(input logic [27:0] e, input logic c);
		logic [3:0] cs;
		cs = ~(4'h1 << e[25:24]);
		if (density_i == sam_pkg::DENS_16M)
			f_pin = c ? {e[11], cs[3:2], 1'b0, e[24:23], e[10:3]} : {e[11], cs[3:2], e[22:12]};
		else if (four_bank_i)
			f_pin = c ? {e[11], e[12], 2'h0, e[26:25], e[10:3]} : {e[11], e[12], e[24:13]};
		else
			f_pin = c ? {e[11], 3'h0, e[26:25], e[10:3]} : {e[11], e[24:12]};
	endfunction
	function automatic logic [1:0] f_cs(input logic [27:0] e);
		if (density_i == sam_pkg::DENS_16M)
			f_cs = ~(2'h1 << e[25:24]);
		else if (density_i == sam_pkg::DENS_64M)
			f_cs = ~(2'h1 << e[26]);
		else
			f_cs = 2'h2;
	endfunction
	function automatic logic f_bad(input logic [27:0] e);
		logic [3:0] pm;
		pm = populated_i | sam_pkg::BANK0_MASK;
		if (density_i == sam_pkg::DENS_16M)
			f_bad = e[27] | !pm[e[25:24]];
		else
			f_bad = e[27] | (density_i == sam_pkg::DENS_64M && !pm[e[26]]);
	endfunction
	task automatic acc(input logic [26:0] a, input logic g);
		logic [27:0] e;
		logic [7:0] n0;
		int n;
		e = {1'b0, a} + (g ? 28'h0 : {1'b0, gfx_size_i});
		n0 = acts_q;
		@(negedge clk_i);
		chk(32'(req_ready_o), 32'h1);
		req_addr_i = a;
		req_gfx_i = g;
		req_valid_i = 1'b1;
		@(negedge clk_i);
		req_valid_i = 1'b0;
		n = 0;
		while (done_o !== 1'b1 && n < 20)
		begin
			@(posedge clk_i);
			#1;
			n++;
		end
		if (n == 20)
		begin
			failures++;
			stop_test();
		end
		chk(32'(n), f_bad(e) ? 32'h1 : 32'(sam_pkg::RCD_CYC + (sync_strap_i ? 32'h0 : sam_pkg::ASYNC_EXTRA_CYC) + 32'h3));
		chk(32'(err_o), 32'(f_bad(e)));
		if (f_bad(e))
			chk(32'(acts_q), 32'(n0));
		else
		begin
			chk(32'(row_q), 32'(f_pin(e, 1'b0)));
			chk(32'(col_q), 32'(f_pin(e, 1'b1)));
			chk(32'(cs_q), 32'(f_cs(e)));
		end
	endtask
	initial
	begin
		void'($urandom(32'h56E0));
		repeat (4) @(negedge clk_i);
		nrst_i = 1'b1;
		for (int m = 0; m < 12; m++)
		begin
			@(negedge clk_i);
			density_i = 2'(m / 4);
			four_bank_i = m[1];
			sync_strap_i = m[0];
			populated_i = 4'($urandom);
			gfx_size_i = 27'($urandom & 32'hFFFF0) | 27'h10;
			mclk_div_i = 4'($urandom);
			repeat (4) @(negedge clk_i);
			chk(32'(mclk_div_o), sync_strap_i ? 32'h1 : 32'(mclk_div_i));
			acc(27'h7FFFFFF, 1'b0);
			acc(27'h0, 1'b1);
			repeat (20) acc(27'($urandom) & (m < 4 ? 27'h3EFFFFF : 27'h7FFFFFF), 1'($urandom));
		end
		stop_test();
	end
endmodule
`default_nettype wire

// ==== sim/sam_sdram_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module sam_sdram_model
(
	input  wire logic        clk_i,
	input  wire logic [13:0] pins_i,
	input  wire logic [1:0]  cs_n_i,
	input  wire logic        ras_n_i,
	input  wire logic        cas_n_i,
	output logic [13:0]      row_o,
	output logic [13:0]      col_o,
	output logic [1:0]       cs_o,
	output logic [7:0]       acts_o
);
	initial acts_o = 8'h0;
	// only two true selects once wide parts are fitted, bank 0 always answers
	always @(posedge clk_i)
	begin
		if (!ras_n_i)
		begin
			row_o <= pins_i;
			cs_o <= cs_n_i;
			acts_o <= acts_o + 8'h1;
		end
		if (!cas_n_i)
			col_o <= pins_i;
	end
endmodule
`default_nettype wire
